// ==== src/ptt_pkg.sv ====
// package for the paged translation block: entry layout, operation codes,
// table sizes and walk timing.
// assumes a 10 MHz processor clock and a 24-bit virtual address space.
`default_nettype none
package ptt_pkg;
  // ==========================================================
  // table geometry
  localparam int PAGE_W = 13;
  localparam int OFFS_W = 11;
  localparam int VA_W = 24;
  localparam int PAGES = 8192;
  localparam logic [12:0] LAST_PAGE = 13'h1FFF;
  localparam int ENTRY_BYTES = 4;
  localparam int TABLE_BYTES = PAGES * ENTRY_BYTES;
  // ==========================================================
  // lookaside geometry, direct mapped on low page bits
  localparam int TLB_IDX_W = 4;
  localparam int TLB_N = 16;
  localparam int TLB_TAG_W = PAGE_W - TLB_IDX_W;
  // ==========================================================
  // walk timing
  localparam int CLK_KHZ = 10000;
  localparam int WALK_NS = 1430;
  localparam int WALK_CYC = (WALK_NS * CLK_KHZ) / 1000000;
  localparam logic [3:0] WALK_LOAD = 4'(WALK_CYC - 1);
  // ==========================================================
  // entry, bit 0 is the msb of the word
  typedef struct packed {
    logic attached;         // bit 0
    logic accessible;       // bit 1
    logic [2:0] rsv_hi;     // bits 2-4
    logic [2:0] aux;        // bits 5-7
    logic [12:0] frame;     // bits 8-20
    logic ref_bit;          // bit 21
    logic chg_bit;          // bit 22
    logic fetch_prot;       // bit 23
    logic [3:0] acc_ctl;    // bits 24-27
    logic [3:0] rsv_lo;     // bits 28-31
  } ptt_entry_t;
  localparam ptt_entry_t ENTRY_ZERO = 32'h00000000;
  // ==========================================================
  // page operations
  typedef enum logic [3:0] {
    OP_ATTACH = 4'h0,
    OP_DETACH = 4'h1,
    OP_ENABLE = 4'h2,
    OP_REVOKE = 4'h3,
    OP_WR_AUX = 4'h4,
    OP_RD_AUX = 4'h5,
    OP_WR_KEY = 4'h6,
    OP_RD_KEY = 4'h7,
    OP_CLR_TOUCH = 4'h8,
    OP_FLUSH = 4'h9
  } ptt_op_t;
  localparam logic [1:0] CC_OK = 2'h0;
  localparam logic [1:0] CC_NOT_ATTACHED = 2'h1;
  // operation request carrier
  typedef struct packed {
    ptt_op_t code;
    logic [12:0] page;
    logic [12:0] frame;
    logic [6:0] data;
  } ptt_op_req_t;
endpackage : ptt_pkg
`default_nettype wire

// ==== src/ptt_translator.sv ====
// instruction-side translator: translation table, lookaside, page ops.
// assumes requests are synchronous to clk_sys_i and held until taken.
// Contract
// - table holds one four-byte entry per page, 8192 entries, 32K bytes.
// - entry bit 0 is one while the page is attached to a frame.
// - attach op sets the attached bit, detach op clears it.
// - bit 1 marks accessible; enable op sets it, revoke op clears it.
// - accessible never stands without attached.
// - bits 5-7 are software bits, written and read by aux ops.
// - bits 8-20 hold the frame, written when attach assigns a frame.
// - bits 21-27 hold reference, change, fetch-protect, four access bits.
// - key ops write and read all seven key bits; aux ops reach ref, change.
// - clear-touched zeroes reference, reports prior reference and change.
// - reference set on any access, change set on a store.
// - clear reset makes first N entries attached, accessible, zero-filled.
// - clear reset zeroes software and key bits of every entry.
// - clear reset gives first N entries their frame, others zero.
// - on a miss, address bits 8-20 pick the table entry.
// - accessible entry: frame joined with bits 21-31; walk takes 14 cycles, 1.4 us.
// - inaccessible entry raises a page-access fault, instruction suppressed.
// - lookaside serves only instruction addresses, not channel programs.
// - lookaside looked up first; hit adds no walk, miss walks.
// - after enable, the pair is loaded on the next reference.
// - revoke searches the lookaside and invalidates a match.
// - lookaside purged only on reset; flush op is invalid.
`default_nettype none
module ptt_translator (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clear_reset_i,
  input wire logic [13:0] frames_i,
  input wire logic xl_valid_i,
  input wire logic [23:0] xl_vaddr_i,
  input wire logic xl_store_i,
  input wire logic op_valid_i,
  input wire ptt_pkg::ptt_op_req_t op_req_i,
  output logic idle_o,
  output logic xl_done_o,
  output logic xl_fault_o,
  output logic [23:0] xl_raddr_o,
  output logic op_done_o,
  output logic op_invalid_o,
  output logic [1:0] op_cc_o,
  output logic [6:0] op_rdata_o,
  output logic zfill_valid_o,
  output logic [12:0] zfill_frame_o
);
  // ==========================================================
  // helpers
  // page index of a virtual address, bits 8-20 counted from the msb
  function automatic logic [12:0] ptt_page_of(input logic [23:0] va);
    ptt_page_of = va[23:11];
  endfunction : ptt_page_of
  // entry as left by clear reset
  function automatic ptt_pkg::ptt_entry_t ptt_init_entry(
    input logic owned, input logic [12:0] idx);
    ptt_pkg::ptt_entry_t e;
    e = ptt_pkg::ENTRY_ZERO;
    if (owned) begin
      e.attached = 1'b1;
      e.accessible = 1'b1;
      e.frame = idx;
    end
    ptt_init_entry = e;
  endfunction : ptt_init_entry
  // ==========================================================
  // state
  typedef enum logic [5:0] {
    S_START = 6'h01,
    S_INIT = 6'h02,
    S_IDLE = 6'h04,
    S_XLAT = 6'h08,
    S_WALK = 6'h10,
    S_OP = 6'h20
  } ptt_state_t;
  ptt_state_t state, next_state;
  logic [12:0] init_idx;
  logic [13:0] frames_n;
  logic [3:0] walk_cnt;
  logic [23:0] req_vaddr;
  ptt_pkg::ptt_op_req_t req_op;
  // table memory, one word per page
  logic [31:0] tbl [ptt_pkg::PAGES];
  logic tlb_valid [ptt_pkg::TLB_N];
  logic [8:0] tlb_tag [ptt_pkg::TLB_N];
  logic [12:0] tlb_frame [ptt_pkg::TLB_N];
  logic [12:0] rd_page, va_page;
  ptt_pkg::ptt_entry_t cur, tbl_wd;
  logic [3:0] va_idx, op_idx;
  logic req_store, tlb_hit, tbl_we, init_owned;
  logic next_xl_done, next_xl_fault, next_op_done, next_op_invalid;
  logic [23:0] next_raddr;
  logic [1:0] next_cc;
  logic [6:0] next_rdata;
  // ==========================================================
  // lookups
  assign va_page = ptt_page_of(req_vaddr);
  assign va_idx = va_page[3:0];
  assign op_idx = req_op.page[3:0];
  assign tlb_hit = tlb_valid[va_idx] && (tlb_tag[va_idx] == va_page[12:4]);
  assign init_owned = ({1'b0, init_idx} < frames_n);
  // one read port, shared by whichever state owns the table
  always_comb begin
    if (state == S_INIT) begin
      rd_page = init_idx;
    end else if (state == S_OP) begin
      rd_page = req_op.page;
    end else begin
      rd_page = va_page;
    end
  end
  assign cur = tbl[rd_page];
  // ==========================================================
  // entry update and answers
  always_comb begin
    tbl_we = 1'b0;
    tbl_wd = cur;
    next_xl_done = 1'b0;
    next_xl_fault = 1'b0;
    next_raddr = xl_raddr_o;
    next_op_done = 1'b0;
    next_op_invalid = 1'b0;
    next_cc = op_cc_o;
    next_rdata = op_rdata_o;
    case (state)
      S_INIT: begin
        tbl_we = 1'b1;
        tbl_wd = ptt_init_entry(init_owned, init_idx);
      end
      S_XLAT: begin
        if (tlb_hit) begin
          next_xl_done = 1'b1;
          next_raddr = {tlb_frame[va_idx], req_vaddr[10:0]};
          tbl_we = 1'b1;
          tbl_wd.ref_bit = 1'b1;
          tbl_wd.chg_bit = cur.chg_bit | req_store;
        end
      end
      S_WALK: begin
        if (walk_cnt == 4'h0) begin
          next_xl_done = 1'b1;
          if (cur.accessible) begin
            next_raddr = {cur.frame, req_vaddr[10:0]};
            tbl_we = 1'b1;
            tbl_wd.ref_bit = 1'b1;
            tbl_wd.chg_bit = cur.chg_bit | req_store;
          end else begin
            next_xl_fault = 1'b1;
          end
        end
      end
      S_OP: begin
        next_op_done = 1'b1;
        next_cc = ptt_pkg::CC_OK;
        case (req_op.code)
          ptt_pkg::OP_ATTACH: begin
            tbl_we = 1'b1;
            tbl_wd.attached = 1'b1;
            tbl_wd.frame = req_op.frame;
          end
          ptt_pkg::OP_DETACH: begin
            tbl_we = 1'b1;
            tbl_wd.attached = 1'b0;
            tbl_wd.accessible = 1'b0;
          end
          ptt_pkg::OP_ENABLE: begin
            if (cur.attached) begin
              tbl_we = 1'b1;
              tbl_wd.accessible = 1'b1;
            end else begin
              next_cc = ptt_pkg::CC_NOT_ATTACHED;
            end
          end
          ptt_pkg::OP_REVOKE: begin
            tbl_we = 1'b1;
            tbl_wd.accessible = 1'b0;
          end
          ptt_pkg::OP_WR_AUX: begin
            tbl_we = 1'b1;
            tbl_wd.aux = req_op.data[4:2];
            tbl_wd.ref_bit = req_op.data[1];
            tbl_wd.chg_bit = req_op.data[0];
          end
          ptt_pkg::OP_RD_AUX: begin
            next_rdata = {2'h0, cur.aux, cur.ref_bit, cur.chg_bit};
          end
          ptt_pkg::OP_WR_KEY: begin
            tbl_we = 1'b1;
            tbl_wd.ref_bit = req_op.data[6];
            tbl_wd.chg_bit = req_op.data[5];
            tbl_wd.fetch_prot = req_op.data[4];
            tbl_wd.acc_ctl = req_op.data[3:0];
          end
          ptt_pkg::OP_RD_KEY: begin
            next_rdata = {cur.ref_bit, cur.chg_bit, cur.fetch_prot,
                          cur.acc_ctl};
          end
          ptt_pkg::OP_CLR_TOUCH: begin
            tbl_we = 1'b1;
            tbl_wd.ref_bit = 1'b0;
            next_cc = {cur.ref_bit, cur.chg_bit};
          end
          default: next_op_invalid = 1'b1;
        endcase
      end
      default: tbl_we = 1'b0;
    endcase
  end
  // ==========================================================
  // sequencing; clear reset overrides any work in flight
  always_comb begin
    next_state = state;
    case (state)
      S_START: next_state = S_INIT;
      S_INIT: next_state = (init_idx == ptt_pkg::LAST_PAGE) ? S_IDLE : S_INIT;
      S_IDLE: begin
        // translation first so fetches are never starved by page ops
        if (xl_valid_i) begin
          next_state = S_XLAT;
        end else if (op_valid_i) begin
          next_state = S_OP;
        end
      end
      S_XLAT: next_state = tlb_hit ? S_IDLE : S_WALK;
      S_WALK: next_state = (walk_cnt == 4'h0) ? S_IDLE : S_WALK;
      S_OP: next_state = S_IDLE;
      default: next_state = S_START;
    endcase
    if (clear_reset_i) begin
      next_state = S_START;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= S_START;
    end else begin
      state <= next_state;
    end
  end
  // ==========================================================
  // init walk and frame count capture
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_idx <= 13'h0000;
      frames_n <= 14'h0000;
    end else if (state == S_START) begin
      init_idx <= 13'h0000;
      frames_n <= frames_i;
    end else if (state == S_INIT) begin
      init_idx <= init_idx + 13'h0001;
    end
  end
  // walk timer stands in for the table fetch latency
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      walk_cnt <= 4'h0;
    end else if (state == S_XLAT) begin
      walk_cnt <= ptt_pkg::WALK_LOAD;
    end else if (state == S_WALK && walk_cnt != 4'h0) begin
      walk_cnt <= walk_cnt - 4'h1;
    end
  end
  // request capture; only instruction addresses enter here
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_vaddr <= 24'h000000;
      req_store <= 1'b0;
      req_op <= '0;
    end else if (state == S_IDLE) begin
      if (xl_valid_i) begin
        req_vaddr <= xl_vaddr_i;
        req_store <= xl_store_i;
      end else if (op_valid_i) begin
        req_op <= op_req_i;
      end
    end
  end
  // table write port; no reset, the init walk fills it
  always_ff @(posedge clk_sys_i) begin
    if (tbl_we) begin
      tbl[rd_page] <= tbl_wd;
    end
  end
  // ==========================================================
  // lookaside maintenance
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < ptt_pkg::TLB_N; i++) begin
        tlb_valid[i] <= 1'b0;
        tlb_tag[i] <= 9'h000;
        tlb_frame[i] <= 13'h0000;
      end
    end else if (state == S_START) begin
      for (int i = 0; i < ptt_pkg::TLB_N; i++) begin
        tlb_valid[i] <= 1'b0;
      end
    end else if (state == S_WALK && walk_cnt == 4'h0 && cur.accessible) begin
      tlb_valid[va_idx] <= 1'b1;
      tlb_tag[va_idx] <= va_page[12:4];
      tlb_frame[va_idx] <= cur.frame;
    end else if (state == S_OP && (req_op.code == ptt_pkg::OP_REVOKE ||
                 req_op.code == ptt_pkg::OP_DETACH)) begin
      if (tlb_tag[op_idx] == req_op.page[12:4]) begin
        tlb_valid[op_idx] <= 1'b0;
      end
    end
  end
  // ==========================================================
  // registered outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_o <= 1'b0;
      xl_done_o <= 1'b0;
      xl_fault_o <= 1'b0;
      xl_raddr_o <= 24'h000000;
      op_done_o <= 1'b0;
      op_invalid_o <= 1'b0;
      op_cc_o <= 2'h0;
      op_rdata_o <= 7'h00;
      zfill_valid_o <= 1'b0;
      zfill_frame_o <= 13'h0000;
    end else begin
      idle_o <= (next_state == S_IDLE);
      xl_done_o <= next_xl_done;
      xl_fault_o <= next_xl_fault;
      xl_raddr_o <= next_raddr;
      op_done_o <= next_op_done;
      op_invalid_o <= next_op_invalid;
      op_cc_o <= next_cc;
      op_rdata_o <= next_rdata;
      zfill_valid_o <= (state == S_INIT) && init_owned;
      zfill_frame_o <= init_idx;
    end
  end
endmodule : ptt_translator
`default_nettype wire

// ==== testbench/ptt_issue_model.sv ====
// issuing side model: raises translation requests
// assumes issue is called at a falling edge with the block idle
`default_nettype none
module ptt_issue_model (
  input wire logic clk_sys_i,
  input wire logic done_i,
  output logic xl_valid_o,
  output logic [23:0] xl_vaddr_o,
  output logic xl_store_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    xl_valid_o = 1'b0;
    xl_vaddr_o = 24'h000000;
    xl_store_o = 1'b0;
  end
  // held through the taking edge; scrambled after so stale values never pass
  task automatic issue(input logic [23:0] va, input logic st,
                       output int lat);
    xl_valid_o = 1'b1;
    xl_vaddr_o = va;
    xl_store_o = st;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    xl_valid_o = 1'b0;
    xl_vaddr_o = ~va;
    xl_store_o = ~st;
    lat = 0;
    while (done_i !== 1'b1 && lat < 40) begin
      @(negedge clk_sys_i);
      lat++;
    end
    if (done_i !== 1'b1) begin
      lat = -1;
    end
  endtask : issue
endmodule : ptt_issue_model
`default_nettype wire

// ==== testbench/ptt_props.sv ====
// checker on the translator ports
// assumes a bind from the bench top, one clock
`default_nettype none
module ptt_props (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clear_reset_i,
  input wire logic xl_valid_i,
  input wire logic [23:0] xl_vaddr_i,
  input wire logic op_valid_i,
  input wire ptt_pkg::ptt_op_req_t op_req_i,
  input wire logic idle_o,
  input wire logic xl_done_o,
  input wire logic xl_fault_o,
  input wire logic [23:0] xl_raddr_o,
  input wire logic op_done_o,
  input wire logic op_invalid_o,
  input wire logic zfill_valid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // helpers
  logic [10:0] offs;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  // clear reset drops a request with no answer
  default disable iff (!rst_n_i || clear_reset_i);
  sequence xl_take;
    idle_o && xl_valid_i;
  endsequence
  sequence op_take;
    idle_o && op_valid_i && !xl_valid_i;
  endsequence
  // offset of the last taken address
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      offs <= 11'h000;
    end else if (idle_o && xl_valid_i) begin
      offs <= xl_vaddr_i[10:0];
    end
  end
  // ====================
  // checks
  chk_xl_latency: assert property (
    xl_take |-> (##2 xl_done_o) or (##16 xl_done_o))
    else $error("translation latency off");
  chk_xl_busy: assert property (
    xl_take |=> !idle_o ##1 (idle_o == xl_done_o))
    else $error("idle too early");
  chk_op_latency: assert property (
    op_take |-> ##2 op_done_o) else $error("op latency off");
  chk_flush_invalid: assert property (
    op_take ##0 (op_req_i.code == ptt_pkg::OP_FLUSH) |-> ##2 op_invalid_o)
    else $error("flush not invalid");
  chk_op_accepted: assert property (
    op_take ##0 (op_req_i.code < ptt_pkg::OP_FLUSH) |-> ##2 !op_invalid_o)
    else $error("valid op refused");
  chk_fault_done: assert property (
    xl_fault_o |-> xl_done_o) else $error("fault without done");
  chk_done_pulse: assert property (
    xl_done_o |=> !xl_done_o) else $error("done not a pulse");
  chk_raddr_offs: assert property (
    xl_done_o && !xl_fault_o |-> xl_raddr_o[10:0] == offs)
    else $error("offset not carried");
  chk_zfill_init: assert property (
    zfill_valid_o |-> !idle_o) else $error("zero fill when idle");
endmodule : ptt_props
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench with a table and lookaside model
// assumes translations come from the issue model, ops from here
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic clear_reset_i = 1'b0;
  logic [13:0] frames_i = 14'h0000;
  logic op_valid_i = 1'b0;
  ptt_pkg::ptt_op_req_t op_req_i = '0;
  logic xl_valid_i, xl_store_i, idle_o, xl_done_o, xl_fault_o;
  logic op_done_o, op_invalid_o, zfill_valid_o;
  logic [23:0] xl_vaddr_i, xl_raddr_o;
  logic [1:0] op_cc_o;
  logic [6:0] op_rdata_o;
  logic [12:0] zfill_frame_o;
  int n_mismatch = 0;
  int checks = 0;
  int seed = 72;
  ptt_pkg::ptt_entry_t mt [8192];
  int tlbp [16];
  always #50 clk_sys_i = ~clk_sys_i;
  ptt_translator i_ptt_translator (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .clear_reset_i(clear_reset_i),
    .frames_i(frames_i), .xl_valid_i(xl_valid_i),
    .xl_vaddr_i(xl_vaddr_i), .xl_store_i(xl_store_i),
    .op_valid_i(op_valid_i), .op_req_i(op_req_i), .idle_o(idle_o),
    .xl_done_o(xl_done_o), .xl_fault_o(xl_fault_o),
    .xl_raddr_o(xl_raddr_o), .op_done_o(op_done_o),
    .op_invalid_o(op_invalid_o), .op_cc_o(op_cc_o),
    .op_rdata_o(op_rdata_o), .zfill_valid_o(zfill_valid_o),
    .zfill_frame_o(zfill_frame_o));
  ptt_issue_model i_ptt_issue_model (.clk_sys_i(clk_sys_i),
    .done_i(xl_done_o), .xl_valid_o(xl_valid_i),
    .xl_vaddr_o(xl_vaddr_i), .xl_store_o(xl_store_i));
  // ====================
  // compare and report
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic bail();
    n_mismatch++;
    tally_and_finish();
  endtask : bail
  task automatic wait_idle();
    int k;
    k = 0;
    while (idle_o !== 1'b1) begin
      @(negedge clk_sys_i);
      k++;
      if (k > 40) bail();
    end
  endtask : wait_idle
  // ====================
  // init: model reload and zero-fill walk
  task automatic do_init();
    int k;
    int n;
    k = 0;
    n = 0;
    for (int i = 0; i < 8192; i++) begin
      mt[i] = ptt_pkg::ENTRY_ZERO;
      mt[i].attached = (i < frames_i);
      mt[i].accessible = (i < frames_i);
      mt[i].frame = (i < frames_i) ? 13'(i) : 13'h0000;
    end
    for (int i = 0; i < 16; i++) tlbp[i] = -1;
    while (idle_o !== 1'b1) begin
      @(negedge clk_sys_i);
      n++;
      if (n > 9000) bail();
      if (zfill_valid_o === 1'b1) begin
        check("zfill frame", zfill_frame_o, 13'(k));
        k++;
      end
    end
    check("zfill count", k, frames_i);
  endtask : do_init
  // ====================
  // one translation against the model
  task automatic xlate(input int pg, input int st);
    logic [23:0] va;
    int lat;
    ptt_pkg::ptt_entry_t e;
    va = {13'(pg), 11'($random(seed))};
    e = mt[pg];
    wait_idle();
    i_ptt_issue_model.issue(va, 1'(st), lat);
    if (lat < 0) bail();
    check("latency", lat, tlbp[pg % 16] == pg ? 1 : 15);
    check("fault", xl_fault_o, !e.accessible);
    if (e.accessible) begin
      check("raddr", xl_raddr_o, {e.frame, va[10:0]});
      mt[pg].ref_bit = 1'b1;
      mt[pg].chg_bit = e.chg_bit | 1'(st);
      tlbp[pg % 16] = pg;
    end
  endtask : xlate
  // ====================
  // one page op against the model
  task automatic op(input int c, input int pg, input int fr, input int d);
    ptt_pkg::ptt_entry_t e;
    logic [1:0] cc;
    logic [6:0] rd;
    int k;
    e = mt[pg];
    cc = 2'h0;
    rd = 7'h00;
    case (c)
      0: begin
        e.attached = 1'b1;
        e.frame = 13'(fr);
      end
      1: begin
        e.attached = 1'b0;
        e.accessible = 1'b0;
      end
      2: if (e.attached) begin
        e.accessible = 1'b1;
      end else begin
        cc = 2'h1;
      end
      3: e.accessible = 1'b0;
      4: {e.aux, e.ref_bit, e.chg_bit} = 5'(d);
      5: rd = {2'h0, e.aux, e.ref_bit, e.chg_bit};
      6: {e.ref_bit, e.chg_bit, e.fetch_prot, e.acc_ctl} = 7'(d);
      7: rd = {e.ref_bit, e.chg_bit, e.fetch_prot, e.acc_ctl};
      8: begin
        cc = {e.ref_bit, e.chg_bit};
        e.ref_bit = 1'b0;
      end
      default: ;
    endcase
    if ((c == 1 || c == 3) && tlbp[pg % 16] == pg) tlbp[pg % 16] = -1;
    mt[pg] = e;
    wait_idle();
    op_valid_i = 1'b1;
    op_req_i = {4'(c), 13'(pg), 13'(fr), 7'(d)};
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    op_valid_i = 1'b0;
    k = 0;
    while (op_done_o !== 1'b1) begin
      @(negedge clk_sys_i);
      k++;
      if (k > 10) bail();
    end
    check("op latency", k, 1);
    check("invalid", op_invalid_o, c == 9);
    check("cc", op_cc_o, cc);
    if (c == 5 || c == 7) check("rdata", op_rdata_o, rd);
  endtask : op
  // ====================
  // scenario list, run after power-on reset and after the first clear reset
  task automatic scen();
    int n;
    n = frames_i;
    op(7, 0, 0, 0);
    op(5, 1, 0, 0);
    xlate(1, 0);
    xlate(1, 1);
    op(7, 1, 0, 0);
    op(8, 1, 0, 0);
    op(7, 1, 0, 0);
    xlate(n, 0);
    op(2, n, 0, 0);
    op(0, n, $random(seed) & 8191, 0);
    op(2, n, 0, 0);
    xlate(n, 0);
    xlate(n, 1);
    for (int i = 0; i < 4; i++) begin
      op(6, 2, 0, $random(seed) & 127);
      op(7, 2, 0, 0);
      op(4, 2, 0, $random(seed) & 31);
      op(5, 2, 0, 0);
    end
    op(3, 1, 0, 0);
    xlate(1, 0);
    xlate(0, 0);
    op(9, 0, 0, 0);
    xlate(0, 0);
    op(1, n, 0, 0);
    xlate(n, 0);
  endtask : scen
  // main sequence: reset, run, clear reset with a new frame count, run
  initial begin
    frames_i = 14'(3 + ($random(seed) & 7));
    repeat (20) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    for (int p = 0; p < 2; p++) begin
      do_init();
      scen();
      frames_i = 14'(3 + ($random(seed) & 7));
      clear_reset_i = 1'b1;
      @(negedge clk_sys_i);
      clear_reset_i = 1'b0;
    end
    tally_and_finish();
  end
endmodule : tb
bind ptt_translator ptt_props i_ptt_props (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .clear_reset_i(clear_reset_i),
  .xl_valid_i(xl_valid_i), .xl_vaddr_i(xl_vaddr_i),
  .op_valid_i(op_valid_i), .op_req_i(op_req_i), .idle_o(idle_o),
  .xl_done_o(xl_done_o), .xl_fault_o(xl_fault_o),
  .xl_raddr_o(xl_raddr_o), .op_done_o(op_done_o),
  .op_invalid_o(op_invalid_o), .zfill_valid_o(zfill_valid_o));
`default_nettype wire
